// >>> common/uf2dl_regs.svh
// Constants of the UF2 download engine: address windows, field positions, counts
`ifndef UF2DL_REGS_SVH
`define UF2DL_REGS_SVH

// ==========================================================================
// Block format
// ==========================================================================
`define UF2DL_PAYLOAD_BYTES 32'h0000_0100
`define UF2DL_FAMILY_CODE 32'h5a5a_0001
`define UF2DL_FLAG_SKIP_BIT 0
`define UF2DL_FLAG_FAMILY_BIT 13
`define UF2DL_BYTE_CNT_W 9
`define UF2DL_LAST_BYTE 9'h0ff

// ==========================================================================
// Address windows
// ==========================================================================
`define UF2DL_FLASH_BASE 32'h1000_0000
`define UF2DL_FLASH_END 32'h1100_0000
`define UF2DL_RAM_BASE 32'h2000_0000
`define UF2DL_RAM_END 32'h2004_2000
`define UF2DL_CACHE_BASE 32'h1500_0000
`define UF2DL_CACHE_END 32'h1500_4000
`define UF2DL_PAGE_MASK 32'h0000_00ff
`define UF2DL_SECTOR_LSB 12
`define UF2DL_SECTOR_MSB 23
`define UF2DL_FLASH_OFS_W 24

// ==========================================================================
// Tracking sizes
// ==========================================================================
`define UF2DL_MAX_BLOCKS 4096
`define UF2DL_BLK_IDX_W 12
`define UF2DL_SEEN_CNT_W 13
`define UF2DL_NUM_SECTORS 4096

// ==========================================================================
// USB descriptors and drive geometry
// ==========================================================================
`define UF2DL_VENDOR_ID 16'h1234
`define UF2DL_PRODUCT_ID 16'h5678
`define UF2DL_EP0_MAX_PKT 8'h40
`define UF2DL_USB_VER_LO 8'h10
`define UF2DL_USB_VER_HI 8'h01
`define UF2DL_DEV_DESC_LEN 8'h12
`define UF2DL_IF_DESC_LEN 8'h09
`define UF2DL_IF_CLASS_VENDOR 8'hff
`define UF2DL_IF_NUM_EPS 8'h02
`define UF2DL_NUM_CONFIGS 8'h01
`define UF2DL_DRIVE_SECTORS 32'h0004_0000
`define UF2DL_DRIVE_FILES 2'h2

`endif

// >>> common/uf2dl_pkg.sv
// Types shared by the UF2 download engine and its testbench
package uf2dl_pkg;

  // ========================================================================
  // Block header as delivered by the drive's sector parser
  // ========================================================================
  typedef struct packed {
    logic magic_ok;            // Sector carried UF2 magic words
    logic [31:0] flags;        // Block flags word
    logic [31:0] target_addr;  // Destination byte address
    logic [31:0] payload_size; // Payload length in bytes
    logic [31:0] block_no;     // Index of this block
    logic [31:0] num_blocks;   // Declared total block count
    logic [31:0] family;       // Family identifier field
  } uf2dl_hdr_t;

  // One byte write towards flash or RAM
  typedef struct packed {
    logic to_flash;     // Flash physical offset when high, else bus address
    logic [31:0] addr;  // Byte address or flash offset
    logic [7:0] data;   // Byte value
  } uf2dl_wr_t;

  // Reboot request
  typedef struct packed {
    logic to_flash;    // Reset then enter flash second stage
    logic [31:0] pc;   // Entry point for a RAM binary
  } uf2dl_boot_t;

  typedef enum logic [2:0] {
    UF2DL_IDLE, UF2DL_ERASE, UF2DL_DATA, UF2DL_NEXT, UF2DL_DRAIN, UF2DL_BOOT, UF2DL_HALT
  } uf2dl_state_t;

endpackage

// >>> rtl/uf2dl_desc_rom.sv
// Device and vendor interface descriptor bytes of the boot device
`timescale 1ns/1ps
`include "uf2dl_regs.svh"

module uf2dl_desc_rom (
  input wire logic sel_if,        // High selects the vendor interface descriptor
  input wire logic [4:0] idx,     // Byte index inside the descriptor
  input wire logic [7:0] if_num,  // Interface number, depends on exposed interfaces
  output logic [7:0] data
);

  // ========================================================================
  // Descriptor lookup
  // ========================================================================
  // Out of range indices read zero so a short descriptor never aliases
  always_comb begin
    data = 8'h00;
    if (sel_if) begin
      case (idx)
        5'h00: data = `UF2DL_IF_DESC_LEN;
        5'h01: data = 8'h04;
        5'h02: data = if_num;
        5'h03: data = 8'h00;
        5'h04: data = `UF2DL_IF_NUM_EPS;
        5'h05: data = `UF2DL_IF_CLASS_VENDOR;
        default: data = 8'h00;                // Subclass, protocol, string: zero
      endcase
    end else begin
      case (idx)
        5'h00: data = `UF2DL_DEV_DESC_LEN;
        5'h01: data = 8'h01;
        5'h02: data = `UF2DL_USB_VER_LO;
        5'h03: data = `UF2DL_USB_VER_HI;
        5'h07: data = `UF2DL_EP0_MAX_PKT;
        5'h08: data = 8'(`UF2DL_VENDOR_ID);
        5'h09: data = 8'(`UF2DL_VENDOR_ID >> 8);
        5'h0a: data = 8'(`UF2DL_PRODUCT_ID);
        5'h0b: data = 8'(`UF2DL_PRODUCT_ID >> 8);
        5'h0d: data = 8'h01;
        5'h0e: data = 8'h01;
        5'h0f: data = 8'h02;
        5'h10: data = 8'h03;
        5'h11: data = `UF2DL_NUM_CONFIGS;
        default: data = 8'h00;
      endcase
    end
  end

endmodule // uf2dl_desc_rom

// >>> rtl/uf2dl_engine.sv
// UF2 block download engine behind the emulated mass-storage drive
`timescale 1ns/1ps
`include "uf2dl_regs.svh"

// What this block does
// - Accept only matching family and 256-byte payload
// - First block's address picks flash or RAM
// - Flash blocks inside flash window, page aligned
// - Flash offsets wrap past fitted flash size
// - RAM binary may target main RAM, any alignment
// - RAM binary may also use flash cache
// - Changed count or type restarts the transfer
// - Blocks with skip flag are never written
// - Flash erased in whole 4 kB sectors
// - Complete once every declared block seen
// - Resent blocks are not written again
// - Flash binary: reset, then enter flash start
// - RAM binary: watchdog boot at lowest main RAM address, else lowest cache address
// - Vendor lockout stops writes, aborts download unless already draining for reboot
// - Present 128MB FAT16 drive, two files only
// - Non-UF2 writes accepted and discarded
// - Invalid files fail silently, no error reported
// - Device descriptor: ids, 64, 1.10, one config
// - Vendor interface: class ff, alt 0, 2 endpoints

module uf2dl_engine (
  input wire logic clk,
  input wire logic arst_n,
  // Block headers from the sector parser
  input wire logic blk_valid,
  input wire uf2dl_pkg::uf2dl_hdr_t blk_hdr,
  output logic blk_ready,
  // Payload bytes following each accepted header, always 256 of them
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  output logic data_ready,
  // Byte writes to flash or RAM
  output logic wr_valid,
  output uf2dl_pkg::uf2dl_wr_t wr,
  input wire logic wr_ready,
  input wire logic mem_idle,
  // Flash sector erase
  output logic erase_valid,
  output logic [31:0] erase_ofs,
  input wire logic erase_done,
  // Fitted flash size as an offset mask
  input wire logic [23:0] flash_wrap_mask,
  // Vendor interface lockout of drive writes
  input wire logic writes_disabled,
  // Reboot request
  output logic boot_valid,
  output uf2dl_pkg::uf2dl_boot_t boot,
  // Status
  output logic download_active,
  output logic drive_write_protect,
  // Drive geometry and descriptor access
  output logic [31:0] drive_sectors,
  output logic [1:0] drive_files,
  input wire logic desc_sel_if,
  input wire logic [4:0] desc_idx,
  input wire logic [7:0] desc_if_num,
  output logic [7:0] desc_data
);

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    uf2dl_pkg::uf2dl_state_t st;            // Sequencer state
    logic active;                           // A transfer is in progress
    logic is_flash;                         // Binary type of current transfer
    logic [31:0] num_blocks;                // Declared count of current transfer
    logic [`UF2DL_SEEN_CNT_W-1:0] seen_cnt; // Distinct blocks received
    logic [`UF2DL_MAX_BLOCKS-1:0] seen;     // One bit per block index
    logic [`UF2DL_NUM_SECTORS-1:0] erased;  // Sectors erased this transfer
    logic [31:0] base;                      // Write base of current block
    logic commit;                           // Current block's bytes are written
    logic [`UF2DL_BYTE_CNT_W-1:0] byte_cnt; // Payload byte position
    logic [32:0] low_key;                   // Lowest block: {not main RAM, addr}
    logic blk_ready;
    logic data_ready;
    logic wr_valid;
    uf2dl_pkg::uf2dl_wr_t wr;
    logic erase_valid;
    logic [31:0] erase_ofs;
    logic boot_valid;
    uf2dl_pkg::uf2dl_boot_t boot;
    logic write_protect;
    logic [7:0] desc_data;
  } uf2dl_regs_t;

  uf2dl_regs_t state_reg;
  uf2dl_regs_t state_next;
  logic [7:0] desc_byte; // Combinational descriptor byte

  uf2dl_desc_rom u_desc (
    .sel_if(desc_sel_if),
    .idx(desc_idx),
    .if_num(desc_if_num),
    .data(desc_byte)
  );

  // ========================================================================
  // Header classification, on the header presented now
  // ========================================================================
  logic hdr_fmt_ok;      // Magic, family and size all match
  logic hdr_in_flash;    // Target inside the flash window and page aligned
  logic hdr_flash_type;  // Address belongs to the flash window at all
  logic hdr_in_ram;      // Whole payload inside main RAM
  logic hdr_in_cache;    // Whole payload inside the flash cache
  logic hdr_skip;        // Skip-content flag set
  logic [31:0] hdr_end;  // One past the last payload byte
  logic [`UF2DL_FLASH_OFS_W-1:0] hdr_flash_ofs; // Wrapped flash offset
  logic [`UF2DL_BLK_IDX_W-1:0] hdr_idx;         // Block index into the bitmap
  logic [`UF2DL_BLK_IDX_W-1:0] hdr_sector;      // Sector index of the offset
  logic [32:0] hdr_key;  // Ordering key for the RAM entry point

  always_comb begin
    hdr_end = blk_hdr.target_addr + `UF2DL_PAYLOAD_BYTES;
    hdr_fmt_ok = blk_hdr.magic_ok && blk_hdr.flags[`UF2DL_FLAG_FAMILY_BIT]
      && (blk_hdr.family == `UF2DL_FAMILY_CODE)
      && (blk_hdr.payload_size == `UF2DL_PAYLOAD_BYTES);
    hdr_flash_type = (blk_hdr.target_addr >= `UF2DL_FLASH_BASE)
      && (blk_hdr.target_addr < `UF2DL_FLASH_END);
    hdr_in_flash = hdr_flash_type
      && ((blk_hdr.target_addr & `UF2DL_PAGE_MASK) == 32'h0000_0000);
    hdr_in_ram = (blk_hdr.target_addr >= `UF2DL_RAM_BASE)
      && (hdr_end <= `UF2DL_RAM_END) && (hdr_end > blk_hdr.target_addr);
    hdr_in_cache = (blk_hdr.target_addr >= `UF2DL_CACHE_BASE)
      && (hdr_end <= `UF2DL_CACHE_END) && (hdr_end > blk_hdr.target_addr);
    hdr_skip = blk_hdr.flags[`UF2DL_FLAG_SKIP_BIT];
    // Wrap instead of reject when the fitted part is smaller than the window
    hdr_flash_ofs = blk_hdr.target_addr[`UF2DL_FLASH_OFS_W-1:0] & flash_wrap_mask;
    hdr_idx = blk_hdr.block_no[`UF2DL_BLK_IDX_W-1:0];
    hdr_sector = hdr_flash_ofs[`UF2DL_SECTOR_MSB:`UF2DL_SECTOR_LSB];
    // Main RAM orders below the flash cache although its address is higher
    hdr_key = {~hdr_in_ram, blk_hdr.target_addr};
  end

  // ========================================================================
  // Next-state logic
  // ========================================================================
  // One sequencer handles every block; a block that is not committed still has
  // its 256 payload bytes drained so the parser never stalls on a bad file
  always_comb begin
    logic take_hdr;
    logic new_xfer;
    logic region_ok;
    logic fresh;
    take_hdr = 1'b0;
    new_xfer = 1'b0;
    region_ok = 1'b0;
    fresh = 1'b0;
    state_next = state_reg;
    state_next.boot_valid = 1'b0;
    state_next.desc_data = desc_byte;
    state_next.write_protect = writes_disabled;
    case (state_reg.st)
      uf2dl_pkg::UF2DL_IDLE: begin
        take_hdr = blk_valid && state_reg.blk_ready;
        if (take_hdr) begin
          state_next.blk_ready = 1'b0;
          state_next.byte_cnt = '0;
          state_next.commit = 1'b0;
          state_next.data_ready = 1'b1;
          state_next.st = uf2dl_pkg::UF2DL_DATA;
          // Non-UF2 sectors and lockout: consume, store nothing
          if (hdr_fmt_ok && !writes_disabled) begin
            // A different count or binary type discards the old transfer
            new_xfer = !state_reg.active || (blk_hdr.num_blocks != state_reg.num_blocks)
              || (hdr_flash_type != state_reg.is_flash);
            region_ok = hdr_flash_type ? hdr_in_flash : (hdr_in_ram || hdr_in_cache);
            if (new_xfer) begin
              state_next.active = 1'b1;
              state_next.is_flash = hdr_flash_type;
              state_next.num_blocks = blk_hdr.num_blocks;
              state_next.seen_cnt = '0;
              state_next.seen = '0;
              state_next.erased = '0;
              state_next.low_key = {1'b1, 32'hffff_ffff};
            end
            // Counts beyond the tracking bitmap cannot be completed
            if (blk_hdr.num_blocks > `UF2DL_MAX_BLOCKS
                || blk_hdr.num_blocks == 32'h0000_0000) begin
              state_next.active = 1'b0;
            end else if (region_ok && !hdr_skip
                && (blk_hdr.block_no < blk_hdr.num_blocks)) begin
              fresh = new_xfer || !state_reg.seen[hdr_idx];
              if (fresh) begin
                state_next.commit = 1'b1;
                state_next.seen[hdr_idx] = 1'b1;
                state_next.seen_cnt = (new_xfer ? '0 : state_reg.seen_cnt)
                  + `UF2DL_SEEN_CNT_W'(1);
                if (!hdr_flash_type && (hdr_key < state_next.low_key)) begin
                  state_next.low_key = hdr_key;
                end
                if (hdr_flash_type) begin
                  state_next.base = {8'h00, hdr_flash_ofs};
                  // First touch of a sector erases all of it
                  if (new_xfer || !state_reg.erased[hdr_sector]) begin
                    state_next.erased[hdr_sector] = 1'b1;
                    state_next.erase_valid = 1'b1;
                    state_next.erase_ofs = {8'h00, hdr_sector, 12'h000};
                    state_next.data_ready = 1'b0;
                    state_next.st = uf2dl_pkg::UF2DL_ERASE;
                  end
                end else begin
                  state_next.base = blk_hdr.target_addr;
                end
              end
            end
          end
        end
      end
      uf2dl_pkg::UF2DL_ERASE: begin
        // Payload is held off until the sector is blank
        if (erase_done) begin
          state_next.erase_valid = 1'b0;
          state_next.data_ready = 1'b1;
          state_next.st = uf2dl_pkg::UF2DL_DATA;
        end
      end
      uf2dl_pkg::UF2DL_DATA: begin
        if (state_reg.wr_valid) begin
          // Byte waiting for the memory side; no new byte until it leaves
          if (wr_ready) begin
            state_next.wr_valid = 1'b0;
            state_next.data_ready = (state_reg.byte_cnt != '0);
          end
        end else if (data_valid && state_reg.data_ready) begin
          if (state_reg.commit && state_reg.active) begin
            state_next.wr_valid = 1'b1;
            state_next.wr.to_flash = state_reg.is_flash;
            state_next.wr.addr = state_reg.base
              + {23'h000000, state_reg.byte_cnt};
            state_next.wr.data = data_byte;
            state_next.data_ready = 1'b0;
          end
          state_next.byte_cnt = state_reg.byte_cnt + `UF2DL_BYTE_CNT_W'(1);
          if (state_reg.byte_cnt == `UF2DL_LAST_BYTE) begin
            state_next.byte_cnt = '0;
            state_next.data_ready = 1'b0;
          end
        end
        if (state_next.byte_cnt == '0 && !state_next.wr_valid
            && !state_next.data_ready && state_reg.st == uf2dl_pkg::UF2DL_DATA
            && (state_reg.byte_cnt != '0 || state_reg.wr_valid)) begin
          state_next.st = uf2dl_pkg::UF2DL_NEXT;
        end
      end
      uf2dl_pkg::UF2DL_NEXT: begin
        if (state_reg.active && state_reg.seen_cnt
            == state_reg.num_blocks[`UF2DL_SEEN_CNT_W-1:0]) begin
          state_next.st = uf2dl_pkg::UF2DL_DRAIN;
        end else begin
          state_next.blk_ready = 1'b1;
          state_next.st = uf2dl_pkg::UF2DL_IDLE;
        end
      end
      uf2dl_pkg::UF2DL_DRAIN: begin
        // Memory side must have finished the final block before reboot
        if (mem_idle) begin
          state_next.st = uf2dl_pkg::UF2DL_BOOT;
        end
      end
      uf2dl_pkg::UF2DL_BOOT: begin
        state_next.boot_valid = 1'b1;
        state_next.boot.to_flash = state_reg.is_flash;
        // Flash entry is the second stage at the start of flash
        state_next.boot.pc = state_reg.is_flash ? `UF2DL_FLASH_BASE
          : state_reg.low_key[31:0];
        state_next.active = 1'b0;
        state_next.st = uf2dl_pkg::UF2DL_HALT;
      end
      default: begin
        // Waits here for the system reset that the reboot request causes
        state_next.st = uf2dl_pkg::UF2DL_HALT;
      end
    endcase
    // Lockout drops the transfer unless draining or booting; the block in flight drains uncommitted
    if (writes_disabled && state_reg.st != uf2dl_pkg::UF2DL_BOOT
        && state_reg.st != uf2dl_pkg::UF2DL_HALT
        && state_reg.st != uf2dl_pkg::UF2DL_DRAIN) begin
      state_next.active = 1'b0;
      state_next.commit = 1'b0;
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.st <= uf2dl_pkg::UF2DL_IDLE;
      state_reg.blk_ready <= 1'b1;
      state_reg.low_key <= {1'b1, 32'hffff_ffff};
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Outputs, all straight from registers
  // ========================================================================
  assign blk_ready = state_reg.blk_ready;
  assign data_ready = state_reg.data_ready;
  assign wr_valid = state_reg.wr_valid;
  assign wr = state_reg.wr;
  assign erase_valid = state_reg.erase_valid;
  assign erase_ofs = state_reg.erase_ofs;
  assign boot_valid = state_reg.boot_valid;
  assign boot = state_reg.boot;
  assign download_active = state_reg.active;
  assign drive_write_protect = state_reg.write_protect;
  assign desc_data = state_reg.desc_data;

  // Fixed drive geometry: 128MB of 512-byte sectors, two listed files
  logic [31:0] drive_sectors_reg;
  logic [1:0] drive_files_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_sectors_reg <= `UF2DL_DRIVE_SECTORS;
      drive_files_reg <= `UF2DL_DRIVE_FILES;
    end else begin
      drive_sectors_reg <= `UF2DL_DRIVE_SECTORS;
      drive_files_reg <= `UF2DL_DRIVE_FILES;
    end
  end
  assign drive_sectors = drive_sectors_reg;
  assign drive_files = drive_files_reg;

endmodule // uf2dl_engine

// >>> testbench/uf2dl_engine_monitor.sv
// Port checker of the UF2 download engine
`timescale 1ns/1ps
`include "uf2dl_regs.svh"
module uf2dl_engine_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic blk_valid,
  input wire logic blk_ready,
  input wire logic data_ready,
  input wire logic wr_valid,
  input wire uf2dl_pkg::uf2dl_wr_t wr,
  input wire logic mem_idle,
  input wire logic erase_valid,
  input wire logic [31:0] erase_ofs,
  input wire logic erase_done,
  input wire logic [23:0] flash_wrap_mask,
  input wire logic writes_disabled,
  input wire logic boot_valid,
  input wire uf2dl_pkg::uf2dl_boot_t boot,
  input wire logic download_active,
  input wire logic [31:0] drive_sectors,
  input wire logic [1:0] drive_files
);
  // ==========
  // One clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Header taken, then engine busy with payload or erase
  sequence s_take; blk_valid && blk_ready; endsequence
  sequence s_answer; !blk_ready && (data_ready || erase_valid); endsequence
  AST_TAKE: assert property (s_take |=> s_answer) else $error("header not answered");
  AST_SECTOR: assert property (erase_valid |-> erase_ofs[11:0] == 12'h000)
    else $error("erase not sector aligned");
  AST_ERASE_END: assert property (erase_valid && erase_done |=> !erase_valid && data_ready)
    else $error("erase end wrong");
  // Flash offsets never leave the fitted size
  AST_WRAP: assert property (wr_valid && wr.to_flash |-> wr.addr[31:24] == 8'h00
    && (wr.addr[23:0] & ~flash_wrap_mask) == 24'h000000) else $error("flash offset unwrapped");
  AST_RAM: assert property (wr_valid && !wr.to_flash |->
    (wr.addr >= `UF2DL_RAM_BASE && wr.addr < `UF2DL_RAM_END) ||
    (wr.addr >= `UF2DL_CACHE_BASE && wr.addr < `UF2DL_CACHE_END)) else $error("ram write outside");
  AST_LOCK: assert property (writes_disabled |=> !download_active)
    else $error("lockout ignored");
  // Reboot only once memory went idle two cycles back
  AST_DRAIN: assert property (boot_valid |-> !wr_valid && $past(mem_idle, 2))
    else $error("boot before drain");
  AST_BOOT_PC: assert property (boot_valid && boot.to_flash |-> boot.pc == `UF2DL_FLASH_BASE)
    else $error("flash boot pc wrong");
  AST_ONCE: assert property (boot_valid |=> !boot_valid [*8]) else $error("boot repeated");
  AST_GEOM: assert property (drive_sectors == `UF2DL_DRIVE_SECTORS && drive_files == 2'h2)
    else $error("drive geometry wrong");
endmodule // uf2dl_engine_checker

bind uf2dl_engine uf2dl_engine_checker i_chk (.clk, .arst_n, .blk_valid, .blk_ready,
  .data_ready, .wr_valid, .wr, .mem_idle, .erase_valid, .erase_ofs, .erase_done,
  .flash_wrap_mask, .writes_disabled, .boot_valid, .boot, .download_active,
  .drive_sectors, .drive_files);

// >>> testbench/uf2dl_host_model.sv
// Host model: writes UF2 blocks into the drive
`timescale 1ns/1ps
module uf2dl_host_model (
  input wire logic clk,
  output logic blk_valid,
  output uf2dl_pkg::uf2dl_hdr_t blk_hdr,
  input wire logic blk_ready,
  output logic data_valid,
  output logic [7:0] data_byte,
  input wire logic data_ready
);
  // ==========
  // Idle lines at time zero
  initial begin
    blk_valid = 1'b0;
    blk_hdr = '0;
    data_valid = 1'b0;
    data_byte = 8'h00;
  end
  // Header then its whole payload; random gaps model a slow host
  task automatic send(input uf2dl_pkg::uf2dl_hdr_t h, input logic [7:0] s);
    @(negedge clk);
    blk_valid = 1'b1;
    blk_hdr = h;
    @(posedge clk);
    while (blk_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    blk_valid = 1'b0;
    blk_hdr = ~h; // Released lines keep no stale header
    for (int i = 0; i < 256; i++) begin
      if ($urandom % 3 == 0) begin
        data_valid = 1'b0;
        data_byte = ~data_byte;
        @(negedge clk);
      end
      data_valid = 1'b1;
      data_byte = s + 8'(i);
      @(posedge clk);
      while (data_ready !== 1'b1) @(posedge clk);
      @(negedge clk);
    end
    data_valid = 1'b0;
    data_byte = ~data_byte;
  endtask
endmodule // uf2dl_host_model

// >>> testbench/test_uf2dl_engine.sv
// Self-checking bench of the UF2 download engine
`timescale 1ns/1ps
`include "uf2dl_regs.svh"
module test_uf2dl_engine;
  logic clk, blk_valid, blk_ready, data_valid, data_ready, wr_valid, erase_valid;
  logic boot_valid, download_active, drive_write_protect;
  logic arst_n = 1'b0;
  logic wr_ready = 1'b0;
  logic mem_idle = 1'b1;
  logic erase_done = 1'b0;
  logic writes_disabled = 1'b0;
  logic desc_sel_if = 1'b0;
  logic [4:0] desc_idx = 5'h00;
  logic [7:0] desc_if_num = 8'h00;
  logic [23:0] flash_wrap_mask = 24'h1fffff; // Two megabytes fitted
  logic [7:0] data_byte, desc_data;
  logic [31:0] erase_ofs, drive_sectors;
  logic [1:0] drive_files;
  uf2dl_pkg::uf2dl_hdr_t blk_hdr;
  uf2dl_pkg::uf2dl_wr_t wr;
  uf2dl_pkg::uf2dl_boot_t boot;
  logic [40:0] wq[$]; // Expected writes, oldest first
  logic [32:0] bq[$]; // Expected reboot requests
  int num_errors = 0;
  int checks_done = 0;
  localparam logic [31:0] FL = 32'h00002000; // Family present
  localparam logic [31:0] PS = `UF2DL_PAYLOAD_BYTES;
  // Descriptor table: select, index, byte
  logic [13:0] dt [9] = '{{1'b0, 5'h02, 8'h10}, {1'b0, 5'h03, 8'h01}, {1'b0, 5'h07, 8'h40},
    {1'b0, 5'h11, 8'h01}, {1'b1, 5'h04, 8'h02}, {1'b1, 5'h05, 8'hff}, {1'b0, 5'h00, 8'h12},
    {1'b0, 5'h0b, 8'(`UF2DL_PRODUCT_ID >> 8)}, {1'b1, 5'h03, 8'h00}};

  uf2dl_engine i_dut (.clk, .arst_n, .blk_valid, .blk_hdr, .blk_ready, .data_valid,
    .data_byte, .data_ready, .wr_valid, .wr, .wr_ready, .mem_idle, .erase_valid, .erase_ofs,
    .erase_done, .flash_wrap_mask, .writes_disabled, .boot_valid, .boot, .download_active,
    .drive_write_protect, .drive_sectors, .drive_files, .desc_sel_if, .desc_idx,
    .desc_if_num, .desc_data);
  uf2dl_host_model i_host (.clk, .blk_valid, .blk_hdr, .blk_ready, .data_valid, .data_byte,
    .data_ready);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Memory side: random stalls and slow erase
  always @(negedge clk) begin
    wr_ready <= 1'($urandom % 2);
    erase_done <= erase_valid && !erase_done && ($urandom % 4 == 0);
    mem_idle <= !wr_valid;
  end
  // Results taken against the oldest note
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (wq.size() == 0) check(64'(wr), ~64'(wr));
      else check(64'(wr), 64'(wq.pop_front()));
    end
    if (boot_valid === 1'b1) begin
      if (bq.size() == 0) check(64'(boot), ~64'(boot));
      else check(64'(boot), 64'(bq.pop_front()));
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rst();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
  endtask
  // Sends one block; notes its writes when it should be committed
  task automatic blk(input logic [31:0] ta, no, n, fl, sz, input bit ex);
    logic [7:0] s;
    logic f;
    logic [31:0] a;
    s = 8'($urandom);
    f = (ta[31:24] == 8'h10);
    a = f ? {8'h00, ta[23:0] & flash_wrap_mask} : ta;
    for (int i = 0; i < 256 && ex; i++) wq.push_back({f, a + 32'(i), s + 8'(i)});
    i_host.send({1'b1, fl, ta, sz, no, n, `UF2DL_FAMILY_CODE}, s);
  endtask
  task automatic settle();
    for (int k = 0; k < 4000 && wq.size() + bq.size() != 0; k++) @(posedge clk);
    check(64'(wq.size() + bq.size()), 64'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'hcb04733d));
    rst();
    blk(32'h10200100, 0, 2, FL, PS, 1);
    blk(32'h10200100, 0, 2, FL, PS, 0);
    blk(32'h10000200, 1, 2, 32'h0, PS, 0);
    blk(32'h10000200, 1, 2, 32'h2001, PS, 0);
    blk(32'h10000200, 1, 2, FL, 32'hff, 0);
    blk(32'h10000280, 1, 2, FL, PS, 0);
    blk(32'h10000100, 0, 3, FL, PS, 1);
    blk(32'h10001000, 1, 3, FL, PS, 1);
    bq.push_back({1'b1, `UF2DL_FLASH_BASE});
    blk(32'h10002000, 2, 3, FL, PS, 1);
    settle();
    rst();
    blk(32'h15000010, 0, 2, FL, PS, 1);
    writes_disabled = 1'b1;
    blk(32'h20000000, 0, 2, FL, PS, 0);
    check(64'(drive_write_protect), 64'h1);
    check(64'(download_active), 64'h0);
    @(negedge clk);
    writes_disabled = 1'b0;
    blk(32'h15000010, 0, 2, FL, PS, 1);
    blk(32'h20041f80, 1, 2, FL, PS, 0);
    bq.push_back({1'b0, 32'h20000003});
    blk(32'h20000003, 1, 2, FL, PS, 1);
    settle();
    @(negedge clk);
    desc_if_num = 8'($urandom);
    for (int j = 0; j < 9; j++) begin
      desc_sel_if = dt[j][13];
      desc_idx = dt[j][12:8];
      @(negedge clk);
      check(64'(desc_data), 64'(dt[j][7:0]));
    end
    desc_idx = 5'h02;
    @(negedge clk);
    check(64'(desc_data), 64'(desc_if_num));
    report_and_stop();
  end
  // Hang guard
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule // test_uf2dl_engine
